// ===== hw/asf_stage.sv
// Purpose: Protection and fault control of a stereo switching power stage
// Assumes: Link inputs are asynchronous to ref_clk; fault sensors are levels
// Notes:   Error latch cleared at reset_n falling edge
`timescale 1ns/1ps
`default_nettype none
// Functional notes
// (R01) Reset low: all transistors off, Hi-Z
// (R02) Controller holds reset low for bootstrap charge
// (R03) Release reset only with valid PWM
// (R04) Controller never holds PWM high constantly
// (R05) Power-down: reset low before PWM stops
// (R06) Shutdown status low while protecting
// (R07) Reset low releases shutdown status high
// (R08) Warning low above 125 degrees
// (R09) Two status lines encode chip state
// (R10) Any error forces Hi-Z
// (R11) Latch cleared at reset fall
// (R12) Reset low mutes switching
// (R13) Overcurrent per high and low side
// (R14) One overtemperature detector for all
// (R15) Shared undervoltage lockout on gate supply
// (R16) Latching mode holds Hi-Z until reset toggle
// (R17) Autorecovery resumes after short delay
// (R18) Recovery delay counts PWM cycles, shared
// (R19) Start Hi-Z, then accept PWM
// (R20) Straps select protection and output mode; output_cfg_strap only sets cfg_error when it is not OUT_CFG_BTL
// (R21) Test mode disables all protection
// (R22) Recovery count is a parameter
module asf_stage
	import asf_pkg::*;
#(
	parameter int unsigned AR_CYCLES = asf_pkg::AR_PWM_CYCLES
) (
	input  wire logic       ref_clk,
	input  wire logic       nrst,
	asf_link_if.stage       link,
	input  wire logic [1:0] overcurrent_hs,
	input  wire logic [1:0] overcurrent_ls,
	input  wire logic       overtemp_fault,
	input  wire logic       temp_warning,
	input  wire logic       gate_drive_low,
	input  wire logic       prot_strap_a,
	input  wire logic       prot_strap_b,
	input  wire logic       output_cfg_strap,
	input  wire logic       protection_off_mode,
	output logic [1:0]      gate_hs,
	output logic [1:0]      gate_ls,
	output logic            out_hiz,
	output logic            cfg_error
);
	import asf_pkg::*;

	// ****************************************
	// Input synchronisers
	// ****************************************
	logic [2:0] s1_q, s2_q;
	logic [2:0] raw;
	assign raw = {link.pwm_input, link.reset_n};
	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			s1_q <= 3'h0;
			s2_q <= 3'h0;
		end else begin
			s1_q <= raw;
			s2_q <= s1_q;
		end
	end
	logic [1:0] pwm;
	logic       rst_in;
	assign pwm    = s2_q[2:1];
	assign rst_in = s2_q[0];

	// ****************************************
	// Mode and faults
	// ****************************************
	logic [1:0] mode_q, mode_d;
	logic       cfg_q, cfg_d;
	logic       rst_prev_q, rst_prev_d;
	logic [1:0] pwm_prev_q, pwm_prev_d;
	logic       oc, err_now, prot_off;
	assign oc       = |{overcurrent_hs, overcurrent_ls};                 // (R13)
	assign prot_off = protection_off_mode;
	assign err_now  = !prot_off && (oc || overtemp_fault || gate_drive_low); // (R14) (R15) (R21)

	// ****************************************
	// Protection state machine
	// ****************************************
	asf_state_t  st_q, st_d;
	logic [15:0] ar_q, ar_d;
	logic        ote_q, ote_d;
	logic        pwm_rise;
	assign pwm_rise = pwm[0] && !pwm_prev_q[0];

	always_comb begin
		st_d       = st_q;
		ar_d       = ar_q;
		ote_d      = ote_q;
		rst_prev_d = rst_in;
		pwm_prev_d = pwm;
		mode_d     = mode_q;
		cfg_d      = cfg_q;
		if (rst_in && !rst_prev_q) begin
			mode_d = {prot_strap_a, prot_strap_b};                   // (R20)
			cfg_d  = ({prot_strap_a, prot_strap_b} != STRAP_LATCHING &&
			          {prot_strap_a, prot_strap_b} != STRAP_AUTO) ||
			         (output_cfg_strap != OUT_CFG_BTL);
		end
		if (!rst_in && rst_prev_q) begin
			st_d  = ASF_HIZ;                                         // (R11)
			ote_d = 1'b0;
		end else if (!rst_in) begin
			st_d = ASF_HIZ;                                          // (R01) (R12)
		end else begin
			unique case (st_q)
				ASF_HIZ: begin
					if (err_now) begin
						st_d  = ASF_FAULT;
						ote_d = overtemp_fault;
					end else begin
						st_d = ASF_RUN;                              // (R19)
					end
				end
				ASF_RUN: begin
					if (err_now) begin
						st_d  = ASF_FAULT;                           // (R10)
						ote_d = overtemp_fault;
					end
				end
				ASF_FAULT: begin
					if (mode_q == STRAP_AUTO && !err_now) begin      // (R16) (R17)
						st_d = ASF_RECOVER;
						ar_d = 16'h0000;
					end
				end
				ASF_RECOVER: begin
					if (err_now) begin
						st_d = ASF_FAULT;
					end else if (pwm_rise) begin
						if (ar_q >= 16'(AR_CYCLES - 1)) begin        // (R18) (R22)
							st_d  = ASF_RUN;
							ote_d = 1'b0;
						end else begin
							ar_d = ar_q + 16'h0001;
						end
					end
				end
			endcase
		end
	end

	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			st_q       <= ASF_HIZ;
			ar_q       <= 16'h0000;
			ote_q      <= 1'b0;
			rst_prev_q <= 1'b0;
			pwm_prev_q <= 2'h0;
			mode_q     <= STRAP_LATCHING;
			cfg_q      <= 1'b0;
		end else begin
			st_q       <= st_d;
			ar_q       <= ar_d;
			ote_q      <= ote_d;
			rst_prev_q <= rst_prev_d;
			pwm_prev_q <= pwm_prev_d;
			mode_q     <= mode_d;
			cfg_q      <= cfg_d;
		end
	end

	// ****************************************
	// Output stage and status pins
	// ****************************************
	logic       run;
	logic       prot;
	assign run  = (st_q == ASF_RUN) && rst_in;
	assign prot = (st_q == ASF_FAULT) || (st_q == ASF_RECOVER);

	logic [1:0] hs_q, ls_q;
	logic       hiz_q, sd_q, tw_q;
	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			hs_q  <= 2'h0;
			ls_q  <= 2'h0;
			hiz_q <= 1'b1;
			sd_q  <= 1'b0;
			tw_q  <= 1'b0;
		end else begin
			hs_q  <= run ? pwm : 2'h0;                                // (R01) (R10)
			ls_q  <= run ? ~pwm : 2'h0;
			hiz_q <= !run;
			sd_q  <= rst_in && prot;                                  // (R06) (R07)
			tw_q  <= temp_warning || (rst_in && prot && ote_q);       // (R08) (R09)
		end
	end

	assign gate_hs      = hs_q;
	assign gate_ls      = ls_q;
	assign out_hiz      = hiz_q;
	assign cfg_error    = cfg_q;
	assign link.sd_out  = 1'b0;
	assign link.sd_oe_n = !sd_q;
	assign link.tw_out  = 1'b0;
	assign link.tw_oe_n = !tw_q;
endmodule
`default_nettype wire

// ===== hw/asf_pkg.sv
// Purpose: Shared constants and types for the power stage control link
// Assumes: ref_clk at 25 MHz
// Notes:   Used by both ends, the link checker and the bench
package asf_pkg;
	localparam int unsigned CLK_HZ           = 25_000_000;
	localparam int unsigned BST_CHARGE_US    = 800;
	localparam int unsigned BST_READY_US     = 1000;
	localparam int unsigned BST_CHARGE_CYC   = (BST_CHARGE_US * (CLK_HZ / 1_000_000));
	localparam int unsigned BST_READY_CYC    = (BST_READY_US * (CLK_HZ / 1_000_000));
	localparam int unsigned AR_PWM_CYCLES    = 16;
	localparam int unsigned PWM_DIV          = 66;
	localparam logic [1:0]  STRAP_LATCHING   = 2'h1;
	localparam logic [1:0]  STRAP_AUTO       = 2'h0;
	localparam logic        OUT_CFG_BTL      = 1'h0;

	typedef enum logic [1:0] {
		ASF_HIZ     = 2'b00,
		ASF_RUN     = 2'b01,
		ASF_FAULT   = 2'b10,
		ASF_RECOVER = 2'b11
	} asf_state_t;

	typedef enum logic [1:0] {
		ASF_H_OFF    = 2'b00,
		ASF_H_CHARGE = 2'b01,
		ASF_H_ON     = 2'b10
	} asf_host_state_t;
endpackage

// ===== hw/asf_link_if.sv
// Purpose: Link between the controller and the power stage
// Assumes: Open-drain status lines with pullup, resolved here
// Notes:   No clocking block
`timescale 1ns/1ps
`default_nettype none
interface asf_link_if;
	logic [1:0] pwm_input;
	logic       reset_n;
	logic       sd_out;
	logic       sd_oe_n;
	logic       tw_out;
	logic       tw_oe_n;
	logic       shutdown_status_n;
	logic       temp_warning_n;

	// Open-drain resolve with pullup
	assign shutdown_status_n = (!sd_oe_n) ? sd_out : 1'b1;
	assign temp_warning_n    = (!tw_oe_n) ? tw_out : 1'b1;

	modport stage (
		input  pwm_input,
		input  reset_n,
		output sd_out,
		output sd_oe_n,
		output tw_out,
		output tw_oe_n
	);
	modport ctrl (
		output pwm_input,
		output reset_n,
		input  shutdown_status_n,
		input  temp_warning_n
	);
endinterface
`default_nettype wire

// ===== hw/asf_ctrl.sv
// Purpose: Controller end: PWM source and reset sequencing
// Assumes: Status lines asynchronous; pwm_duty is user level
// Notes:   PWM near 379 kHz from ref_clk, duty set by pwm_duty
`timescale 1ns/1ps
`default_nettype none
module asf_ctrl
	import asf_pkg::*;
#(
	parameter int unsigned READY_CYC = asf_pkg::BST_READY_CYC
) (
	input  wire logic       ref_clk,
	input  wire logic       nrst,
	asf_link_if.ctrl        link,
	input  wire logic       power_on,
	input  wire logic       mute,
	input  wire logic [5:0] pwm_duty,
	output logic            ready,
	output logic            stage_fault_n,
	output logic            stage_warn_n
);
	import asf_pkg::*;

	// ****************************************
	// Status synchronisers
	// ****************************************
	logic [1:0] s1_q, s2_q;
	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			s1_q <= 2'h3;
			s2_q <= 2'h3;
		end else begin
			s1_q <= {link.shutdown_status_n, link.temp_warning_n};
			s2_q <= s1_q;
		end
	end

	// ****************************************
	// PWM generator, never held high
	// ****************************************
	logic [6:0] ph_q, ph_d;
	logic [1:0] pwm_q, pwm_d;
	always_comb begin
		ph_d  = (ph_q >= 7'(PWM_DIV - 1)) ? 7'h00 : ph_q + 7'h01;       // (R03)
		pwm_d = {2{ph_q < {1'b0, pwm_duty}}};                             // (R04)
	end

	// ****************************************
	// Reset sequencing
	// ****************************************
	asf_host_state_t st_q, st_d;
	logic [31:0]     cnt_q, cnt_d;
	logic            pwm_en_q, pwm_en_d;
	logic            rn_q, rn_d;
	always_comb begin
		st_d     = st_q;
		cnt_d    = cnt_q;
		pwm_en_d = pwm_en_q;
		rn_d     = 1'b0;
		unique case (st_q)
			ASF_H_OFF: begin
				pwm_en_d = 1'b0;
				cnt_d    = 32'h0;
				if (power_on) begin
					st_d     = ASF_H_CHARGE;
					pwm_en_d = 1'b1;
				end
			end
			ASF_H_CHARGE: begin
				cnt_d = cnt_q + 32'h1;                                    // (R02)
				if (!power_on) begin
					st_d = ASF_H_OFF;
				end else if (cnt_q >= 32'(READY_CYC)) begin
					st_d = ASF_H_ON;
				end
			end
			ASF_H_ON: begin
				rn_d = !mute;                                             // (R03)
				if (!power_on) begin
					st_d = ASF_H_CHARGE;
					rn_d = 1'b0;                                          // (R05)
					cnt_d = 32'(READY_CYC);
				end
			end
			default: st_d = ASF_H_OFF;
		endcase
		if (st_q == ASF_H_CHARGE && !power_on) begin
			pwm_en_d = 1'b0;                                              // (R05)
		end
	end

	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			st_q     <= ASF_H_OFF;
			cnt_q    <= 32'h0;
			pwm_en_q <= 1'b0;
			rn_q     <= 1'b0;
			ph_q     <= 7'h00;
			pwm_q    <= 2'h0;
		end else begin
			st_q     <= st_d;
			cnt_q    <= cnt_d;
			pwm_en_q <= pwm_en_d;
			rn_q     <= rn_d;
			ph_q     <= ph_d;
			pwm_q    <= pwm_en_q ? pwm_d : 2'h0;
		end
	end

	assign link.pwm_input = pwm_q;
	assign link.reset_n   = rn_q;
	assign ready          = rn_q;
	assign stage_fault_n  = s2_q[1];
	assign stage_warn_n   = s2_q[0];
endmodule
`default_nettype wire

// ===== sim/asf_link_chk.sv
// Purpose: Link checker for the controller and power stage ends
// Assumes: Watches the link interface signals only
// Notes:   Counters track PWM activity
`timescale 1ns/1ps
`default_nettype none
module asf_link_chk
	import asf_pkg::*;
#(
	parameter int unsigned READY_CYC = asf_pkg::BST_READY_CYC
) (
	input wire logic       ref_clk,
	input wire logic       nrst,
	input wire logic [1:0] pwm_input,
	input wire logic       reset_n,
	input wire logic       sd_out,
	input wire logic       sd_oe_n,
	input wire logic       tw_out,
	input wire logic       tw_oe_n,
	input wire logic       shutdown_status_n,
	input wire logic       temp_warning_n
);
	// ****************
	// PWM activity
	// ****************
	logic [1:0]      pwm_q;
	logic [7:0]      chg_q, chg_d;
	logic [1:0][7:0] hi_q, hi_d;
	logic [15:0]     run_q, run_d;
	always_comb begin
		chg_d = (pwm_input != pwm_q) ? 8'h00 : chg_q + 8'(chg_q != 8'hFF);
		for (int i = 0; i < 2; i++) begin
			hi_d[i] = pwm_input[i] ? hi_q[i] + 8'(hi_q[i] != 8'hFF) : 8'h00;
		end
		run_d = (chg_q > 8'(PWM_DIV)) ? 16'h0000 : run_q + 16'(run_q != 16'hFFFF);
	end
	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			pwm_q <= 2'h0;
			chg_q <= 8'hFF;
			hi_q <= '0;
			run_q <= 16'h0000;
		end else begin
			pwm_q <= pwm_input;
			chg_q <= chg_d;
			hi_q <= hi_d;
			run_q <= run_d;
		end
	end
	// ****************
	// Assertions
	// ****************
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (!nrst);
	boot_low_a: assert property ($rose(nrst) |-> !reset_n [*8])
		else $error("reset_n not held low after reset");
	ready_wait_a: assert property ($rose(reset_n) |-> 32'(run_q) + PWM_DIV >= READY_CYC)
		else $error("reset_n released too early");
	pwm_valid_a: assert property ($rose(reset_n) |-> chg_q <= 8'(PWM_DIV))
		else $error("reset_n released without PWM");
	pwm_high_a: assert property (hi_q[0] < 8'(PWM_DIV) && hi_q[1] < 8'(PWM_DIV))
		else $error("PWM held high");
	pwm_fall_a: assert property ($fell(reset_n) |-> chg_q <= 8'(PWM_DIV))
		else $error("PWM stopped before reset_n fell");
	pwm_stop_a: assert property (chg_q > 8'(PWM_DIV) |-> !reset_n)
		else $error("reset_n high with PWM stopped");
	sd_release_a: assert property ($fell(reset_n) |-> ##[1:6] shutdown_status_n)
		else $error("shutdown line not released");
	sd_hold_a: assert property (!reset_n [*6] |-> shutdown_status_n)
		else $error("shutdown line low during reset");
	sd_low_reset_a: assert property (!shutdown_status_n |-> $past(reset_n, 3))
		else $error("shutdown line low without reset_n high");
	cover property ($rose(reset_n));
	cover property ($rose(shutdown_status_n) && reset_n);
	cover property (!shutdown_status_n && !temp_warning_n);
	cover property (!shutdown_status_n && temp_warning_n);
endmodule
`default_nettype wire

// ===== sim/tb_amp_stage_fault_control.sv
// Purpose: Bench for both ends of the power stage link
// Assumes: Short counts through parameters
// Notes:   Row loop, then hand tests
`timescale 1ns/1ps
`default_nettype none
module tb_amp_stage_fault_control;
	import asf_pkg::*;
	localparam int AR_TB = 4;
	typedef struct packed {logic [6:0] flt; logic [1:0] st; logic hiz;} asf_row_t;
	logic       ref_clk, nrst, power_on, mute, sa, sb, sc, poff;
	logic [5:0] pwm_duty;
	logic [6:0] flt;
	logic [1:0] gate_hs, gate_ls;
	logic       out_hiz, cfg_error, ready, fault_n, warn_n;
	int         num_errors = 0;
	int         n_tests = 0;
	asf_row_t   rows [8] = '{'{7'h01, 2'h2, 1'b1}, '{7'h02, 2'h2, 1'b1}, '{7'h04, 2'h2, 1'b1},
		'{7'h08, 2'h2, 1'b1}, '{7'h10, 2'h0, 1'b1}, '{7'h20, 2'h1, 1'b0},
		'{7'h40, 2'h2, 1'b1}, '{7'h00, 2'h3, 1'b0}};
	logic [3:0] cfg_tab [4] = '{4'h7, 4'hD, 4'h4, 4'h0};
	asf_link_if link ();
	asf_stage #(.AR_CYCLES(AR_TB)) asf_stage_inst (.ref_clk(ref_clk), .nrst(nrst), .link(link),
		.overcurrent_hs(flt[1:0]), .overcurrent_ls(flt[3:2]), .overtemp_fault(flt[4]),
		.temp_warning(flt[5]), .gate_drive_low(flt[6]), .prot_strap_a(sa), .prot_strap_b(sb),
		.output_cfg_strap(sc), .protection_off_mode(poff), .gate_hs(gate_hs),
		.gate_ls(gate_ls), .out_hiz(out_hiz), .cfg_error(cfg_error));
	asf_ctrl #(.READY_CYC(200)) asf_ctrl_inst (.ref_clk(ref_clk), .nrst(nrst), .link(link),
		.power_on(power_on), .mute(mute), .pwm_duty(pwm_duty), .ready(ready),
		.stage_fault_n(fault_n), .stage_warn_n(warn_n));
	asf_link_chk #(.READY_CYC(200)) asf_link_chk_inst (.ref_clk(ref_clk), .nrst(nrst),
		.pwm_input(link.pwm_input), .reset_n(link.reset_n), .sd_out(link.sd_out),
		.sd_oe_n(link.sd_oe_n), .tw_out(link.tw_out), .tw_oe_n(link.tw_oe_n),
		.shutdown_status_n(link.shutdown_status_n), .temp_warning_n(link.temp_warning_n));
	// ****************
	// Tasks
	// ****************
	task automatic final_report();
		$display("errors %0d checks %0d", num_errors, n_tests);
		if (num_errors == 0 && n_tests > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		n_tests++;
		if (got !== exp) begin
			num_errors++;
			$display("BAD %0t got %h exp %h", $time, got, exp);
		end
	endtask
	task automatic cyc(input int n);
		repeat (n) @(posedge ref_clk);
		#1;
	endtask
	task automatic wait_ready(input logic v);
		for (int i = 0; i < 2000 && ready !== v; i++) @(posedge ref_clk);
		#1;
		chk(8'(ready), 8'(v));
		if (ready !== v) final_report();
	endtask
	task automatic toggle_reset();
		@(posedge ref_clk);
		mute <= 1'b1;
		cyc(8);
		chk({out_hiz, link.shutdown_status_n, gate_hs, gate_ls}, 8'h30);
		@(posedge ref_clk);
		mute <= 1'b0;
		wait_ready(1'b1);
		cyc(8);
	endtask
	// ****************
	// Sequence
	// ****************
	initial begin
		ref_clk = 1'b0;
		forever #20 ref_clk = ~ref_clk;
	end
	initial begin
		int k;
		logic [1:0] p;
		{nrst, power_on, mute, sa, sb, sc, poff, flt} = '0;
		sb = 1'b1;
		pwm_duty = 6'h21;
		repeat (4) @(posedge ref_clk);
		nrst <= 1'b1;
		cyc(2);
		chk({out_hiz, link.shutdown_status_n, ready}, 8'h06);
		@(posedge ref_clk);
		power_on <= 1'b1;
		wait_ready(1'b1);
		cyc(8);
		chk(8'(out_hiz), 8'h00);
		p = link.pwm_input;
		cyc(3);
		chk({gate_hs, gate_ls}, {4'h0, p, ~p});
		foreach (rows[i]) begin
			@(posedge ref_clk);
			flt <= rows[i].flt;
			cyc(8);
			chk({link.temp_warning_n, link.shutdown_status_n}, rows[i].st);
			chk({warn_n, fault_n}, rows[i].st);
			chk({out_hiz, gate_hs & {2{out_hiz}}, gate_ls & {2{out_hiz}}}, 8'(rows[i].hiz)<<4);
			@(posedge ref_clk);
			flt <= 7'h00;
			cyc(8);
			chk({out_hiz, link.shutdown_status_n}, {rows[i].hiz, rows[i].st[0]});
			toggle_reset();
			chk({out_hiz, link.shutdown_status_n, link.temp_warning_n}, 8'h03);
		end
		foreach (cfg_tab[i]) begin
			@(posedge ref_clk);
			{sa, sb, sc} <= cfg_tab[i][3:1];
			toggle_reset();
			chk(8'(cfg_error), 8'(cfg_tab[i][0]));
		end
		@(posedge ref_clk);
		flt <= 7'h01;
		cyc(8);
		@(posedge ref_clk);
		flt <= 7'h00;
		cyc(20);
		chk(8'(out_hiz), 8'h01);
		for (k = 0; k < 1000 && out_hiz !== 1'b0; k++) @(posedge ref_clk);
		#1;
		chk({out_hiz, 7'(k >= (AR_TB - 1) * PWM_DIV - 28 && k <= AR_TB * PWM_DIV)}, 8'h01);
		if (out_hiz !== 1'b0) final_report();
		@(posedge ref_clk);
		poff <= 1'b1;
		flt <= 7'h08;
		cyc(8);
		chk({out_hiz, link.shutdown_status_n}, 8'h01);
		@(posedge ref_clk);
		{poff, flt} <= '0;
		power_on <= 1'b0;
		wait_ready(1'b0);
		cyc(8);
		chk(8'(out_hiz), 8'h01);
		final_report();
	end
endmodule
`default_nettype wire
